//--- core/pec_pkg.sv
// Constants for the pulse event counter
// Operation
// R1: Inputs coded 31 trigger the counter
// R2: Inputs coded 28 clear the count
// R3: Software sets fast type 1 first
// R4: Fast type 0 pulse, 1 digital
// R5: Count restarts after reaching set value
// R6: Output coded 18 on at set value
// R7: Output coded 19 on at designated value
// R8: One increment per trigger rising edge
package pec_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int CNT_W_DEF = 16;
  localparam int ADDR_W = 8;
  localparam int IN_FN_W = 7;
  localparam int OUT_FN_W = 6;
  localparam int LANE_W = 8;
  localparam int ST_W = 2;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_IN_FN = 8'h04;
  localparam logic [7:0] OFF_FAST_FN = 8'h08;
  localparam logic [7:0] OFF_OUT_FN = 8'h0C;
  localparam logic [7:0] OFF_SET_CNT = 8'h10;
  localparam logic [7:0] OFF_DES_CNT = 8'h14;
  localparam logic [7:0] OFF_ACC_CNT = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int ST_SET = 0;
  localparam int ST_DES = 1;
  localparam logic FAST_PULSE = 1'h0;
  localparam logic FAST_DIGITAL = 1'h1;
  localparam logic [6:0] FN_CNT_CLR = 7'h1C;
  localparam logic [6:0] FN_CNT_TRIG = 7'h1F;
  localparam logic [5:0] OUT_SET_HIT = 6'h12;
  localparam logic [5:0] OUT_DES_HIT = 6'h13;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_FAST_TYPE = 1'h0;
  localparam logic [6:0] RST_IN1_FN = 7'h01;
  localparam logic [6:0] RST_IN2_FN = 7'h04;
  localparam logic [6:0] RST_IN3_FN = 7'h07;
  localparam logic [6:0] RST_IN4_FN = 7'h00;
  localparam logic [6:0] RST_FAST_FN = 7'h00;
  localparam logic [5:0] RST_Y_FN = 6'h00;
  localparam logic [5:0] RST_RO1_FN = 6'h01;
  localparam logic [5:0] RST_RO2_FN = 6'h05;
  localparam logic [1:0] RST_MASK = 2'h0;

endpackage : pec_pkg

//--- core/pec_sync.sv
// Two flip-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module pec_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } pec_sync_s;

  pec_sync_s s_reg;
  pec_sync_s s_next;

  // ****************************************
  // Two stages
  // ****************************************
  always_comb
  begin
    s_next.meta = d_i;
    s_next.q = s_reg.meta;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.q;

endmodule : pec_sync
`default_nettype wire

//--- core/pec_top.sv
// Pulse event counter with APB registers
`timescale 1ns/1ns
`default_nettype none
module pec_top #(
  parameter int CNT_W = pec_pkg::CNT_W_DEF
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pec_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic digital_input_one_i,
  input wire logic digital_input_two_i,
  input wire logic digital_input_three_i,
  input wire logic digital_input_four_i,
  input wire logic fast_pulse_pin_i,
  output logic transistor_output_o,
  output logic relay_output_one_o,
  output logic relay_output_two_o,
  output logic irq_o
);

  if (CNT_W < 1 || CNT_W > 32)
  begin : g_chk
    $error("CNT_W must be 1 to 32");
  end

  typedef struct packed {
    logic fast_type;
    logic [3:0][pec_pkg::IN_FN_W-1:0] in_fn;
    logic [pec_pkg::IN_FN_W-1:0] fast_fn;
    logic [pec_pkg::OUT_FN_W-1:0] y_fn;
    logic [pec_pkg::OUT_FN_W-1:0] ro1_fn;
    logic [pec_pkg::OUT_FN_W-1:0] ro2_fn;
    logic [CNT_W-1:0] set_cnt;
    logic [CNT_W-1:0] des_cnt;
    logic [CNT_W-1:0] cnt;
    logic [pec_pkg::ST_W-1:0] stat;
    logic [pec_pkg::ST_W-1:0] mask;
    logic trig_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic y_out;
    logic ro1_out;
    logic ro2_out;
    logic irq;
  } pec_state_s;

  pec_state_s s_reg;
  pec_state_s s_next;
  logic rst_b_q;
  logic [4:0] pins_q;
  logic [3:0] in_q;
  logic fast_q;
  logic trig;
  logic clr_act;
  logic in_trig;
  logic rise;

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  pec_sync #(.WIDTH(1)) u_rst_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(1'b1),
    .q_o(rst_b_q)
  );

  pec_sync #(.WIDTH(5)) u_pin_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_q),
    .d_i({fast_pulse_pin_i, digital_input_four_i, digital_input_three_i,
          digital_input_two_i, digital_input_one_i}),
    .q_o(pins_q)
  );

  assign in_q = pins_q[3:0];
  assign fast_q = pins_q[4];

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic sel_hit(
    input logic [3:0] act,
    input logic [3:0][pec_pkg::IN_FN_W-1:0] fn,
    input logic [pec_pkg::IN_FN_W-1:0] code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      hit = hit | (act[i] && fn[i] == code);
    end
    return hit;
  endfunction : sel_hit

  function automatic logic out_drive(
    input logic [pec_pkg::OUT_FN_W-1:0] fn,
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] set_v,
    input logic [CNT_W-1:0] des_v
  );
    return (fn == pec_pkg::OUT_SET_HIT && cnt == set_v) ||
           (fn == pec_pkg::OUT_DES_HIT && cnt == des_v);
  endfunction : out_drive

  // ****************************************
  // Input decode
  // ****************************************
  // R1: trigger selection
  assign in_trig = sel_hit(in_q, s_reg.in_fn, pec_pkg::FN_CNT_TRIG);
  // R4: fast pin used as digital input only
  assign trig = in_trig | (s_reg.fast_type == pec_pkg::FAST_DIGITAL && fast_q &&
                           s_reg.fast_fn == pec_pkg::FN_CNT_TRIG);
  // R2: clear selection
  assign clr_act = sel_hit(in_q, s_reg.in_fn, pec_pkg::FN_CNT_CLR) |
                   (s_reg.fast_type == pec_pkg::FAST_DIGITAL && fast_q &&
                    s_reg.fast_fn == pec_pkg::FN_CNT_CLR);
  // R8: edge detect
  assign rise = trig & ~s_reg.trig_prev;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic setup;
    logic acc;
    logic mapped;
    logic [31:0] rd;
    logic [pec_pkg::ST_W-1:0] ev;
    setup = psel_i & ~penable_i;
    acc = psel_i & penable_i & s_reg.pready;
    mapped = 1'b1;
    rd = 32'h0;
    ev = '0;
    s_next = s_reg;
    unique case (paddr_i)
      pec_pkg::OFF_CFG: rd[0] = s_reg.fast_type;
      pec_pkg::OFF_IN_FN:
        for (int i = 0; i < 4; i++)
        begin
          rd[i*pec_pkg::LANE_W +: pec_pkg::IN_FN_W] = s_reg.in_fn[i];
        end
      pec_pkg::OFF_FAST_FN: rd[pec_pkg::IN_FN_W-1:0] = s_reg.fast_fn;
      pec_pkg::OFF_OUT_FN: rd[23:0] = {2'h0, s_reg.ro2_fn, 2'h0, s_reg.ro1_fn,
                                       2'h0, s_reg.y_fn};
      pec_pkg::OFF_SET_CNT: rd[CNT_W-1:0] = s_reg.set_cnt;
      pec_pkg::OFF_DES_CNT: rd[CNT_W-1:0] = s_reg.des_cnt;
      pec_pkg::OFF_ACC_CNT: rd[CNT_W-1:0] = s_reg.cnt;
      pec_pkg::OFF_IRQ_STAT: rd[pec_pkg::ST_W-1:0] = s_reg.stat;
      pec_pkg::OFF_IRQ_MASK: rd[pec_pkg::ST_W-1:0] = s_reg.mask;
      default: mapped = 1'b0;
    endcase
    // Bus: one wait-free access phase after setup
    s_next.pready = setup;
    if (setup)
    begin
      s_next.prdata = mapped ? rd : 32'h0;
      s_next.pslverr = ~mapped;
    end
    if (acc && pwrite_i && mapped)
    begin
      unique case (paddr_i)
        pec_pkg::OFF_CFG: s_next.fast_type = pwdata_i[0];
        pec_pkg::OFF_IN_FN:
          for (int i = 0; i < 4; i++)
          begin
            s_next.in_fn[i] = pwdata_i[i*pec_pkg::LANE_W +: pec_pkg::IN_FN_W];
          end
        pec_pkg::OFF_FAST_FN: s_next.fast_fn = pwdata_i[pec_pkg::IN_FN_W-1:0];
        pec_pkg::OFF_OUT_FN:
        begin
          s_next.y_fn = pwdata_i[5:0];
          s_next.ro1_fn = pwdata_i[13:8];
          s_next.ro2_fn = pwdata_i[21:16];
        end
        pec_pkg::OFF_SET_CNT: s_next.set_cnt = pwdata_i[CNT_W-1:0];
        pec_pkg::OFF_DES_CNT: s_next.des_cnt = pwdata_i[CNT_W-1:0];
        pec_pkg::OFF_IRQ_MASK: s_next.mask = pwdata_i[pec_pkg::ST_W-1:0];
        default: s_next.mask = s_reg.mask;
      endcase
    end
    // Read clears only the status bits that were returned
    if (acc && !pwrite_i && paddr_i == pec_pkg::OFF_IRQ_STAT)
    begin
      s_next.stat = s_reg.stat & ~s_reg.prdata[pec_pkg::ST_W-1:0];
    end
    s_next.trig_prev = trig;
    // R2: clear has priority
    if (clr_act)
    begin
      s_next.cnt = '0;
    end
    // R8: count on rising edge
    else if (rise)
    begin
      // R5: restart after set value reached
      if (s_reg.cnt >= s_reg.set_cnt)
      begin
        s_next.cnt = CNT_W'(1);
      end
      else
      begin
        s_next.cnt = s_reg.cnt + CNT_W'(1);
      end
      ev[pec_pkg::ST_SET] = (s_next.cnt == s_reg.set_cnt);
      ev[pec_pkg::ST_DES] = (s_next.cnt == s_reg.des_cnt);
    end
    s_next.stat = s_next.stat | ev;
    // R6: set value outputs
    // R7: designated value outputs
    s_next.y_out = out_drive(s_next.y_fn, s_next.cnt, s_next.set_cnt, s_next.des_cnt);
    s_next.ro1_out = out_drive(s_next.ro1_fn, s_next.cnt, s_next.set_cnt, s_next.des_cnt);
    s_next.ro2_out = out_drive(s_next.ro2_fn, s_next.cnt, s_next.set_cnt, s_next.des_cnt);
    s_next.irq = |(s_next.stat & s_next.mask);
  end

  always_ff @(posedge clk_i or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      s_reg <= '0;
      s_reg.fast_type <= pec_pkg::RST_FAST_TYPE;
      s_reg.in_fn <= {pec_pkg::RST_IN4_FN, pec_pkg::RST_IN3_FN,
                      pec_pkg::RST_IN2_FN, pec_pkg::RST_IN1_FN};
      s_reg.fast_fn <= pec_pkg::RST_FAST_FN;
      s_reg.y_fn <= pec_pkg::RST_Y_FN;
      s_reg.ro1_fn <= pec_pkg::RST_RO1_FN;
      s_reg.ro2_fn <= pec_pkg::RST_RO2_FN;
      s_reg.mask <= pec_pkg::RST_MASK;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign prdata_o = s_reg.prdata;
  assign pready_o = s_reg.pready;
  assign pslverr_o = s_reg.pslverr;
  assign transistor_output_o = s_reg.y_out;
  assign relay_output_one_o = s_reg.ro1_out;
  assign relay_output_two_o = s_reg.ro2_out;
  assign irq_o = s_reg.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_q);

  sequence seq_rise;
    !trig ##1 (trig && !clr_act && s_reg.cnt < s_reg.set_cnt);
  endsequence

  a_trig_count: assert property (seq_rise |=> s_reg.cnt == CNT_W'($past(s_reg.cnt) + 1'b1)) // R1
    else $error("trigger edge did not count");
  a_clear_zero: assert property (clr_act |=> s_reg.cnt == '0) // R2
    else $error("clear input did not zero count");
  a_fast_pulse_ignored: assert property ( // R4
    (s_reg.fast_type == pec_pkg::FAST_PULSE && !in_trig && !s_reg.trig_prev)
      |=> $stable(s_reg.cnt) || s_reg.cnt == '0)
    else $error("fast pin counted in pulse mode");
  a_count_restart: assert property ( // R5
    (rise && !clr_act && s_reg.cnt >= s_reg.set_cnt) |=> s_reg.cnt == CNT_W'(1))
    else $error("count did not restart");
  a_set_out: assert property ((s_reg.y_fn == pec_pkg::OUT_SET_HIT) // R6
    |-> s_reg.y_out == (s_reg.cnt == s_reg.set_cnt))
    else $error("set value output wrong");
  a_des_out: assert property ((s_reg.ro2_fn == pec_pkg::OUT_DES_HIT) // R7
    |-> s_reg.ro2_out == (s_reg.cnt == s_reg.des_cnt))
    else $error("designated value output wrong");
  a_cnt_hold: assert property ((trig && !clr_act)[*2] |=> $stable(s_reg.cnt)) // R8
    else $error("count moved on steady trigger");
  a_bus_ready: assert property ((psel_i && !penable_i) |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after setup");

endmodule : pec_top
`default_nettype wire

//--- testbench/pec_pulse_src.sv
// Photoelectric switch model driving the counter input pins
`timescale 1ns/1ns
`default_nettype none
module pec_pulse_src (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [2:0] which_i,
  output logic [4:0] pins_o,
  output logic busy_o
);
  logic [2:0] tick;
  initial
  begin
    pins_o = 5'h00;
    busy_o = 1'b0;
    tick = 3'h0;
  end
  // pulse lands on one chosen pin
  always @(posedge clk_i)
  begin
    if (busy_o)
    begin
      tick <= tick + 3'h1;
      if (tick == 3'h2)
        pins_o <= 5'h00;
      if (tick == 3'h5)
        busy_o <= 1'b0;
    end
    else if (go_i)
    begin
      pins_o <= 5'h01 << which_i;
      busy_o <= 1'b1;
      tick <= 3'h0;
    end
  end
endmodule : pec_pulse_src
`default_nettype wire

//--- testbench/pec_top_tb.sv
// Self-checking bench for the pulse event counter
`timescale 1ns/1ns
`default_nettype none
module pec_top_tb;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, go, busy, y, r1, r2, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, in_fn;
  logic [4:0] pins;
  logic [2:0] which;
  logic [15:0] cnt, set_v, des_v;
  logic [1:0] stat;
  int failures, n_checks, t, c, i, sd;

  pec_top dut (.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .digital_input_one_i(pins[0]),
    .digital_input_two_i(pins[1]), .digital_input_three_i(pins[2]),
    .digital_input_four_i(pins[3]), .fast_pulse_pin_i(pins[4]), .transistor_output_o(y),
    .relay_output_one_o(r1), .relay_output_two_o(r2), .irq_o(irq));
  pec_pulse_src src (.clk_i(clk), .go_i(go), .which_i(which), .pins_o(pins), .busy_o(busy));

  always #2 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
        @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rdchk

  task automatic pulse(input int k);
    which <= 3'(k);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy)
      @(posedge clk);
  endtask : pulse

  function automatic logic [15:0] nxt(input logic [15:0] v, input logic [15:0] s);
    return (v >= s) ? 16'h0001 : v + 16'h0001;
  endfunction : nxt

  task automatic step();
    if (cnt == set_v)
      stat[0] = 1'b1;
    if (cnt == des_v)
      stat[1] = 1'b1;
    chk("set_hit_out", y, cnt == set_v);
    chk("des_hit_out1", r1, cnt == des_v);
    chk("des_hit_out2", r2, cnt == des_v);
    chk("irq", irq, stat[0]);
    rdchk("acc", pec_pkg::OFF_ACC_CNT, 32'(cnt));
  endtask : step

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  initial
  begin
    {clk, rst_b, psel, penable, pwrite, go, paddr, pwdata, which} = '0;
    failures = 0;
    n_checks = 0;
    sd = $urandom(32'h1A9F8814);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk("in_fn", pec_pkg::OFF_IN_FN, {1'b0, pec_pkg::RST_IN4_FN, 1'b0, pec_pkg::RST_IN3_FN,
      1'b0, pec_pkg::RST_IN2_FN, 1'b0, pec_pkg::RST_IN1_FN});
    rdchk("out_fn", pec_pkg::OFF_OUT_FN, {8'h00, 2'h0, pec_pkg::RST_RO2_FN, 2'h0,
      pec_pkg::RST_RO1_FN, 2'h0, pec_pkg::RST_Y_FN});
    rdchk("cfg", pec_pkg::OFF_CFG, 32'h0);
    rdchk("acc", pec_pkg::OFF_ACC_CNT, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_rd", rd, 32'h0);
    $display("test reset_map done");
    t = $urandom % 4;
    c = (t + 1) % 4;
    set_v = 16'(3 + $urandom % 3);
    des_v = set_v - 16'h0001;
    in_fn = '0;
    in_fn[8*t +: 7] = pec_pkg::FN_CNT_TRIG;
    in_fn[8*c +: 7] = pec_pkg::FN_CNT_CLR;
    apb(1'b1, pec_pkg::OFF_IN_FN, in_fn);
    apb(1'b1, pec_pkg::OFF_OUT_FN, {8'h00, 2'h0, pec_pkg::OUT_DES_HIT, 2'h0,
      pec_pkg::OUT_DES_HIT, 2'h0, pec_pkg::OUT_SET_HIT});
    apb(1'b1, pec_pkg::OFF_SET_CNT, 32'(set_v));
    apb(1'b1, pec_pkg::OFF_DES_CNT, 32'(des_v));
    apb(1'b1, pec_pkg::OFF_IRQ_MASK, 32'h1);
    cnt = '0;
    stat = '0;
    for (i = 0; i <= set_v; i++)
    begin
      pulse(t);
      cnt = nxt(cnt, set_v);
      step();
    end
    rdchk("stat", pec_pkg::OFF_IRQ_STAT, 32'(stat));
    stat = '0;
    rdchk("stat_clr", pec_pkg::OFF_IRQ_STAT, 32'h0);
    chk("irq_clr", irq, 1'b0);
    $display("test count_restart done");
    pulse(c);
    cnt = '0;
    step();
    $display("test clear done");
    apb(1'b1, pec_pkg::OFF_FAST_FN, 32'(pec_pkg::FN_CNT_TRIG));
    pulse(4);
    step();
    apb(1'b1, pec_pkg::OFF_CFG, 32'(pec_pkg::FAST_DIGITAL));
    pulse(4);
    cnt = nxt(cnt, set_v);
    step();
    apb(1'b1, pec_pkg::OFF_FAST_FN, 32'(pec_pkg::FN_CNT_CLR));
    pulse(4);
    cnt = '0;
    step();
    $display("test fast_pin done");
    summarize();
  end
endmodule : pec_top_tb
`default_nettype wire
